// ==== src/pfp_top.sv ====
// Behaviour
// - undervoltage trips after deglitch-plus-one low readings
// - overvoltage threshold 16 bits, 2 mV step
// - overvoltage hysteresis 6 bits, 78.125 mV step
// - overvoltage trips after deglitch-plus-one high readings
// - discharge overcurrent one threshold, 2 mA step
// - discharge overcurrent one needs millisecond dwell time
// - independent discharge overcurrent two threshold
// - discharge overcurrent two uses own dwell, threshold
// - discharge set points 2.5 then 7.5 mV; the coarse step is coded as 7501848 nV
// - round threshold to nearest set point
// - charge threshold, 1.6 then 4.8 mV set points
// - charge overcurrent needs continuous dwell time
// - undervoltage threshold 16 bits, 2 mV step
//
// Register access over APB was decided locally.
`timescale 1ns/1ns
`include "pfp_consts.svh"

module pfp_top #(
    parameter logic [15:0] MS_CYCLES  = 16'(`PFP_MS_CYCLES),
    parameter int          SHUNT_UOHM = `PFP_SHUNT_UOHM
) (
    // system
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    // apb slave
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [19:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    input  wire logic [3:0]                  pstrb,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // front-end readings
    input  wire logic                        meas_valid,
    input  wire logic [15:0]                 pack_voltage,
    input  wire logic [15:0]                 discharge_current,
    input  wire logic [15:0]                 charge_current,
    // fault outputs
    output logic [`PFP_NUM_FAULTS-1:0]       fault_active,
    output logic                             fault_irq
);
    import pfp_pkg::*;

    pfp_state_t q;
    pfp_state_t next_q;

    logic [2:0][39:0] set_point_nv;
    logic [2:0][39:0] reading_nv;

    // nearest set point: fine steps to the knee, coarse above, clamp at top
    function automatic logic [39:0] quantize(input logic [39:0] v,
                                             input logic [39:0] fine,
                                             input logic [39:0] knee,
                                             input logic [39:0] coarse,
                                             input logic [39:0] top);
        logic [39:0] r;
        r = '0;
        if (v <= knee) begin
            r = ((v + (fine >> 1)) / fine) * fine;
        end else begin
            r = knee + ((v - knee + (coarse >> 1)) / coarse) * coarse;
        end
        if (r > top) begin
            r = top;
        end
        return r;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // per channel: 0 discharge one, 1 discharge two, 2 charge
    // compared as shunt sense voltage so no division on the reading side
    for (genvar i = 0; i < 3; i++) begin : g_oc
        logic [39:0] thr_nv;
        assign thr_nv = 40'(q.oc_thr[i]) * `PFP_CURR_LSB_MA * 40'(SHUNT_UOHM);
        assign reading_nv[i] = 40'(i == 2 ? charge_current : discharge_current)
                               * `PFP_CURR_LSB_MA * 40'(SHUNT_UOHM);
        if (i == 2) begin : g_coc
            assign set_point_nv[i] = quantize(thr_nv, `PFP_COC_FINE_NV,
                `PFP_COC_KNEE_NV, `PFP_COC_COARSE_NV, `PFP_COC_TOP_NV);
        end else begin : g_doc
            assign set_point_nv[i] = quantize(thr_nv, `PFP_DOC_FINE_NV,
                `PFP_DOC_KNEE_NV, `PFP_DOC_COARSE_NV, `PFP_DOC_TOP_NV);
        end
    end

    always_comb begin
        logic [17:0]                 idx;
        logic                        mapped;
        logic                        setup;
        logic                        wr;
        logic [31:0]                 rd;
        logic [31:0]                 wv;
        logic [`PFP_NUM_FAULTS-1:0]  clr;
        logic [`PFP_NUM_FAULTS-1:0]  rise;
        logic [39:0]                 v_uv;
        logic [39:0]                 thr_uv;
        logic [39:0]                 hyst_uv;
        logic [11:0]                 dly;
        logic [4:0]                  uv_need;
        logic [4:0]                  ov_need;
        idx     = paddr[19:2];
        mapped  = 1'b0;
        rd      = '0;
        clr     = '0;
        next_q  = q;
        setup   = psel && !penable;
        wr      = psel && penable && pwrite && q.pready && !q.pslverr;
        v_uv    = 40'(pack_voltage) * `PFP_VOLT_LSB_UV;
        thr_uv  = 40'(q.ov_thr) * `PFP_VOLT_LSB_UV;
        hyst_uv = 40'(q.ov_hyst) * `PFP_HYST_LSB_UV;
        uv_need = 5'(q.uv_deg) + 5'h01;
        ov_need = 5'(q.ov_deg) + 5'h01;
        dly     = '0;
        wv      = '0;
        rise    = '0;

        // read decode, answered one cycle after setup
        unique case (idx)
            `PFP_IDX_UV_THR:   begin mapped = 1'b1; rd = 32'(q.uv_thr);    end
            `PFP_IDX_UV_DEG:   begin mapped = 1'b1; rd = 32'(q.uv_deg);    end
            `PFP_IDX_OV_THR:   begin mapped = 1'b1; rd = 32'(q.ov_thr);    end
            `PFP_IDX_OV_HYST:  begin mapped = 1'b1; rd = 32'(q.ov_hyst);   end
            `PFP_IDX_OV_DEG:   begin mapped = 1'b1; rd = 32'(q.ov_deg);    end
            `PFP_IDX_DOC1_THR: begin mapped = 1'b1; rd = 32'(q.oc_thr[0]); end
            `PFP_IDX_DOC1_DLY: begin mapped = 1'b1; rd = 32'(q.oc_dly[0]); end
            `PFP_IDX_DOC2_THR: begin mapped = 1'b1; rd = 32'(q.oc_thr[1]); end
            `PFP_IDX_DOC2_DLY: begin mapped = 1'b1; rd = 32'(q.oc_dly[1]); end
            `PFP_IDX_COC_THR:  begin mapped = 1'b1; rd = 32'(q.oc_thr[2]); end
            `PFP_IDX_COC_DLY:  begin mapped = 1'b1; rd = 32'(q.oc_dly[2]); end
            `PFP_IDX_STATUS:   begin mapped = 1'b1; rd = 32'(q.status);    end
            `PFP_IDX_CLEAR:    begin mapped = 1'b1; rd = '0;               end
            `PFP_IDX_ENABLE:   begin mapped = 1'b1; rd = 32'(q.enable);    end
            `PFP_IDX_ACTIVE:   begin mapped = 1'b1; rd = 32'(q.active);    end
            default:           begin mapped = 1'b0; rd = '0;               end
        endcase
        if (paddr[1:0] != 2'h0) begin
            mapped = 1'b0;
            rd     = '0;
        end

        // zero wait state: pready rises for exactly the first access cycle
        next_q.pready  = setup;
        next_q.pslverr = setup && !mapped;
        next_q.prdata  = (setup && !pwrite) ? rd : '0;

        // writes land on the access edge; read-only registers ignore them
        if (wr) begin
            wv = merge(rd, pwdata, pstrb);
            unique case (idx)
                `PFP_IDX_UV_THR:   next_q.uv_thr    = wv[15:0];
                `PFP_IDX_UV_DEG:   next_q.uv_deg    = wv[3:0];
                `PFP_IDX_OV_THR:   next_q.ov_thr    = wv[15:0];
                `PFP_IDX_OV_HYST:  next_q.ov_hyst   = wv[5:0];
                `PFP_IDX_OV_DEG:   next_q.ov_deg    = wv[3:0];
                `PFP_IDX_DOC1_THR: next_q.oc_thr[0] = wv[15:0];
                `PFP_IDX_DOC1_DLY: next_q.oc_dly[0] = wv[11:0];
                `PFP_IDX_DOC2_THR: next_q.oc_thr[1] = wv[15:0];
                `PFP_IDX_DOC2_DLY: next_q.oc_dly[1] = wv[11:0];
                `PFP_IDX_COC_THR:  next_q.oc_thr[2] = wv[15:0];
                `PFP_IDX_COC_DLY:  next_q.oc_dly[2] = wv[11:0];
                `PFP_IDX_CLEAR:    clr = wv[`PFP_NUM_FAULTS-1:0];
                `PFP_IDX_ENABLE:   next_q.enable = wv[`PFP_NUM_FAULTS-1:0];
                default:           ;
            endcase
        end

        // pack voltage qualification, one step per reading
        if (meas_valid) begin
            if (pack_voltage < q.uv_thr) begin
                if (q.uv_cnt < uv_need) begin
                    next_q.uv_cnt = q.uv_cnt + 5'h01;
                end
                if (q.uv_cnt + 5'h01 >= uv_need) begin
                    next_q.active[`PFP_BIT_UV] = 1'b1;
                end
            end else begin
                next_q.uv_cnt = '0;
                next_q.active[`PFP_BIT_UV] = 1'b0;
            end

            if (pack_voltage > q.ov_thr) begin
                if (q.ov_cnt < ov_need) begin
                    next_q.ov_cnt = q.ov_cnt + 5'h01;
                end
                if (q.ov_cnt + 5'h01 >= ov_need) begin
                    next_q.active[`PFP_BIT_OV] = 1'b1;
                end
            end else begin
                // a broken run restarts the count from zero
                next_q.ov_cnt = '0;
                if (v_uv + hyst_uv < thr_uv) begin
                    next_q.active[`PFP_BIT_OV] = 1'b0;
                end
            end
        end

        // overcurrent dwell: millisecond count restarted by each dip
        for (int i = 0; i < 3; i++) begin
            if (meas_valid) begin
                next_q.oc_above[i] = reading_nv[i] > set_point_nv[i];
            end
            // a zero delay field behaves as the shortest time, one millisecond
            dly = (q.oc_dly[i] == 12'h000) ? 12'h001 : q.oc_dly[i];
            if (!next_q.oc_above[i]) begin
                next_q.oc_sub[i] = '0;
                next_q.oc_ms[i]  = '0;
                next_q.active[`PFP_BIT_DOC1 + i] = 1'b0;
            end else if (!q.active[`PFP_BIT_DOC1 + i]) begin
                if (q.oc_sub[i] >= MS_CYCLES - 16'h0001) begin
                    next_q.oc_sub[i] = '0;
                    next_q.oc_ms[i]  = q.oc_ms[i] + 12'h001;
                    if (q.oc_ms[i] + 12'h001 >= dly) begin
                        next_q.active[`PFP_BIT_DOC1 + i] = 1'b1;
                    end
                end else begin
                    next_q.oc_sub[i] = q.oc_sub[i] + 16'h0001;
                end
            end
        end

        // sticky status: a new trip beats a clear in the same cycle
        rise          = next_q.active & ~q.active;
        next_q.status = (q.status & ~clr) | rise;
        next_q.irq    = |(next_q.status & next_q.enable);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q           <= '0;
            q.uv_thr    <= `PFP_RST_UV_THR;
            q.uv_deg    <= `PFP_RST_UV_DEG;
            q.ov_thr    <= `PFP_RST_OV_THR;
            q.ov_hyst   <= `PFP_RST_OV_HYST;
            q.ov_deg    <= `PFP_RST_OV_DEG;
            q.oc_thr[0] <= `PFP_RST_DOC1_THR;
            q.oc_dly[0] <= `PFP_RST_DOC1_DLY;
            q.oc_thr[1] <= `PFP_RST_DOC2_THR;
            q.oc_dly[1] <= `PFP_RST_DOC2_DLY;
            q.oc_thr[2] <= `PFP_RST_COC_THR;
            q.oc_dly[2] <= `PFP_RST_COC_DLY;
        end else begin
            q <= next_q;
        end
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign fault_active = q.active;
    assign fault_irq    = q.irq;

endmodule

// ==== src/pfp_consts.svh ====
`ifndef PFP_CONSTS_SVH
`define PFP_CONSTS_SVH

// register indices; byte address is four times the index
`define PFP_IDX_UV_THR        18'h07f8e
`define PFP_IDX_UV_DEG        18'h07f91
`define PFP_IDX_OV_THR        18'h07f92
`define PFP_IDX_OV_HYST       18'h07f94
`define PFP_IDX_OV_DEG        18'h07f95
`define PFP_IDX_DOC1_THR      18'h07f96
`define PFP_IDX_DOC1_DLY      18'h07f98
`define PFP_IDX_DOC2_THR      18'h07f9a
`define PFP_IDX_DOC2_DLY      18'h07f9c
`define PFP_IDX_COC_THR       18'h07f9e
`define PFP_IDX_COC_DLY       18'h07fa0
`define PFP_IDX_STATUS        18'h07fc0
`define PFP_IDX_CLEAR         18'h07fc1
`define PFP_IDX_ENABLE        18'h07fc2
`define PFP_IDX_ACTIVE        18'h07fc3

// fault bit positions in status, clear, enable and active
`define PFP_BIT_UV            0
`define PFP_BIT_OV            1
`define PFP_BIT_DOC1          2
`define PFP_BIT_DOC2          3
`define PFP_BIT_COC           4
`define PFP_NUM_FAULTS        5

// reset values in register units
`define PFP_RST_UV_THR        16'h5f50
`define PFP_RST_UV_DEG        4'h1
`define PFP_RST_OV_THR        16'h8278
`define PFP_RST_OV_HYST       6'h03
`define PFP_RST_OV_DEG        4'h1
`define PFP_RST_DOC1_THR      16'h1d4c
`define PFP_RST_DOC1_DLY      12'h064
`define PFP_RST_DOC2_THR      16'h2328
`define PFP_RST_DOC2_DLY      12'h014
`define PFP_RST_COC_THR       16'h0ea6
`define PFP_RST_COC_DLY       12'h014

// scaling: voltage code in uV, hysteresis step in uV, current code in mA
`define PFP_VOLT_LSB_UV       40'h00000007d0
`define PFP_HYST_LSB_UV       40'h000001312d
`define PFP_CURR_LSB_MA       40'h0000000002

// front-end set points in nV: fine step, knee, coarse step, top
`define PFP_DOC_FINE_NV       40'h00002625a0
`define PFP_DOC_KNEE_NV       40'h0004c4b400
`define PFP_DOC_COARSE_NV     40'h0000727818
`define PFP_DOC_TOP_NV        40'h000e4e1c00
`define PFP_COC_FINE_NV       40'h0000186a00
`define PFP_COC_KNEE_NV       40'h00030d4000
`define PFP_COC_COARSE_NV     40'h0000493e00
`define PFP_COC_TOP_NV        40'h000927c000

// timing
`define PFP_CLK_HZ            25000000
`define PFP_MS_PER_S          1000
`define PFP_TICK_MS           1
`define PFP_MS_CYCLES         (`PFP_CLK_HZ / `PFP_MS_PER_S * `PFP_TICK_MS)
`define PFP_SHUNT_UOHM        1000

`endif

// ==== src/pfp_pkg.sv ====
`include "pfp_consts.svh"

package pfp_pkg;

    typedef logic [2:0][15:0] pfp_oc_thr_t;

    typedef struct packed {
        logic [15:0]                     uv_thr;
        logic [3:0]                      uv_deg;
        logic [15:0]                     ov_thr;
        logic [5:0]                      ov_hyst;
        logic [3:0]                      ov_deg;
        logic [2:0][15:0]                oc_thr;
        logic [2:0][11:0]                oc_dly;
        logic [`PFP_NUM_FAULTS-1:0]      status;
        logic [`PFP_NUM_FAULTS-1:0]      enable;
        logic [`PFP_NUM_FAULTS-1:0]      active;
        logic [4:0]                      uv_cnt;
        logic [4:0]                      ov_cnt;
        logic [2:0]                      oc_above;
        logic [2:0][15:0]                oc_sub;
        logic [2:0][11:0]                oc_ms;
        logic                            irq;
        logic [31:0]                     prdata;
        logic                            pready;
        logic                            pslverr;
    } pfp_state_t;

endpackage

// ==== test/pfp_front_end_model.sv ====
`timescale 1ns/1ns
module pfp_front_end_model (
    // bench control
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        req,
    input  wire logic        run,
    input  wire logic        slow,
    input  wire logic [15:0] volt,
    input  wire logic [15:0] dcur,
    input  wire logic [15:0] ccur,
    // readings
    output logic             meas_valid,
    output logic [15:0]      pack_voltage,
    output logic [15:0]      discharge_current,
    output logic [15:0]      charge_current
);
    logic [1:0] gap;
    logic       fire;
    // slow mode gives one reading in four cycles
    assign fire = req || (run && (!slow || gap == 2'h0));
    // buses flip outside a reading so stale data never passes for fresh
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap <= 2'h0;
            meas_valid <= 1'b0;
            {pack_voltage, discharge_current, charge_current} <= '0;
        end else begin
            gap <= gap + 2'h1;
            meas_valid <= fire;
            pack_voltage <= fire ? volt : ~pack_voltage;
            discharge_current <= fire ? dcur : ~discharge_current;
            charge_current <= fire ? ccur : ~charge_current;
        end
    end
endmodule

// ==== test/pfp_top_properties.sv ====
`timescale 1ns/1ns
module pfp_top_properties #(
    parameter logic [15:0] MS_CYCLES = 16'h61a8
) (
    // apb
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [19:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // faults
    input wire logic        meas_valid,
    input wire logic [4:0]  fault_active,
    input wire logic        fault_irq
);
    logic [15:0] since_rst;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) since_rst <= 16'h0;
        else if (since_rst != 16'hffff) since_rst <= since_rst + 16'h1;
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no answer");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error alone");
    a_misalign_err: assert property (
        psel && !penable && paddr[1:0] != 2'h0 |=> pslverr) else $error("misaligned taken");
    a_rdata_idle: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("stray read data");
    a_volt_reading: assert property (
        $changed(fault_active[1:0]) |-> $past(meas_valid)) else $error("fault without reading");
    a_oc_dwell: assert property (
        since_rst < MS_CYCLES |-> fault_active[4:2] == 3'h0) else $error("early trip");
    a_irq_rise: assert property ($rose(fault_irq) |->
        $past(psel && penable && pwrite) || (fault_active & ~$past(fault_active)) != 5'h0)
        else $error("irq without cause");
    a_irq_fall: assert property ($fell(fault_irq) |-> $past(psel && penable && pwrite))
        else $error("irq fell alone");
    c_irq: cover property ($rose(fault_irq));
    c_coc: cover property ($rose(fault_active[4]));
    c_err: cover property (pslverr);
endmodule

bind pfp_top pfp_top_properties #(.MS_CYCLES(MS_CYCLES)) pfp_top_properties_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .meas_valid(meas_valid), .fault_active(fault_active), .fault_irq(fault_irq));

// ==== test/pfp_tb_top.sv ====
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module pfp_tb_top;
    import pfp_pkg::*;
    localparam logic [15:0] MS = 16'h0004;
    logic        pclk, presetn, psel, penable, pwrite, req, run, slow, pready, pslverr, er;
    logic        meas_valid, fault_irq;
    logic [3:0]  pstrb;
    logic [4:0]  fault_active;
    logic [19:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic [15:0] volt, dcur, ccur, pv, dc, cc;
    int          num_errors, n_checks, cyc, ch, dl, h, vh, thr;
    longint      sp;
    int idx [11] = '{16'h7f8e, 16'h7f91, 16'h7f92, 16'h7f94, 16'h7f95, 16'h7f96, 16'h7f98,
                     16'h7f9a, 16'h7f9c, 16'h7f9e, 16'h7fa0};
    int wid [11] = '{16, 4, 16, 6, 4, 16, 12, 16, 12, 16, 12};
    int rst [11] = '{16'h5f50, 1, 16'h8278, 3, 1, 16'h1d4c, 16'h64, 16'h2328, 20, 16'hea6, 20};
    int degs [3] = '{0, 15, 7};
    int thrs [3] = '{45000, 1000, 30000};
    int oci [3] = '{16'h7f96, 16'h7f9a, 16'h7f9e};

    pfp_top #(.MS_CYCLES(MS)) pfp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .meas_valid(meas_valid),
        .pack_voltage(pv), .discharge_current(dc), .charge_current(cc),
        .fault_active(fault_active), .fault_irq(fault_irq));
    pfp_front_end_model pfp_front_end_model_inst (.pclk(pclk), .presetn(presetn), .req(req),
        .run(run), .slow(slow), .volt(volt), .dcur(dcur), .ccur(ccur), .meas_valid(meas_valid),
        .pack_voltage(pv), .discharge_current(dc), .charge_current(cc));

    // sense set point in nV, nearest with ties up; code step is 2 uV on a 1 mohm shunt
    function automatic longint setpt(input longint t, input bit chg);
        longint v, f, k, c, s;
        v = t * 2000;
        f = chg ? 1600000 : 2500000;
        k = chg ? 51200000 : 80000000;
        c = chg ? 4800000 : 7500000;
        if (v <= k) s = (v + f / 2) / f * f;
        else s = k + (v - k + c / 2) / c * c;
        return (s > (chg ? 153600000 : 240000000)) ? (chg ? 153600000 : 240000000) : s;
    endfunction
    task automatic apb(input logic wr, input int a, input logic [31:0] wd,
                       input logic [3:0] st = 4'hf);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, wr, 20'(a), wd, st};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {rd, er} = {prdata, pslverr};
        {psel, penable} <= 2'b00;
        #1;
    endtask
    task automatic shot(input int v);
        @(posedge pclk);
        {volt, req} <= {16'(v), 1'b1};
        @(posedge pclk);
        req <= 1'b0;
        @(posedge pclk);
        #1;
    endtask
    task automatic setc(input longint v, input logic s);
        @(posedge pclk);
        {run, slow} <= {1'b1, s};
        dcur <= (ch == 2) ? 16'h0 : 16'(v);
        ccur <= (ch == 2) ? 16'(v) : 16'h0;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, req, run, slow, paddr, pwdata} = '0;
        {pstrb, volt, dcur, ccur} = {4'hf, 16'd25000, 32'h0};
        w = $urandom(67203);
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 11; i++) begin
            apb(0, idx[i] * 4, 0);
            `CHK(rd, 32'(rst[i]))
            w = $urandom;
            apb(1, idx[i] * 4, w);
            apb(0, idx[i] * 4, 0);
            `CHK(rd, w & ((32'h1 << wid[i]) - 1))
        end
        apb(0, 16'h7f00 * 4, 0);
        `CHK({er, rd}, 33'h100000000)
        apb(1, 16'h7f92 * 4, 32'h1234);
        apb(1, 16'h7f92 * 4 + 2, 32'habcd);
        `CHK(er, 1'b1)
        apb(1, 16'h7f92 * 4, 32'hffff, 4'h1);
        apb(0, 16'h7f92 * 4, 0);
        `CHK(rd, 32'h12ff)
        degs[2] = $urandom_range(14, 1);
        // overvoltage threshold above the undervoltage readings so it cannot latch early
        apb(1, 16'h7f92 * 4, 30000);
        apb(1, 16'h7f8e * 4, 20000);
        foreach (degs[j]) begin
            apb(1, 16'h7f91 * 4, degs[j]);
            repeat (degs[j]) shot(19999);
            shot(20000);
            repeat (degs[j]) shot(19999);
            `CHK(fault_active[0], 1'b0)
            shot(19999);
            `CHK(fault_active[0], 1'b1)
            shot(20000);
            `CHK(fault_active[0], 1'b0)
        end
        foreach (degs[j]) begin
            h = $urandom_range(63, 1);
            apb(1, 16'h7f94 * 4, h);
            apb(1, 16'h7f95 * 4, degs[j]);
            repeat (degs[j]) shot(30001);
            shot(30000);
            repeat (degs[j]) shot(30001);
            `CHK(fault_active[1], 1'b0)
            shot(30001);
            `CHK(fault_active[1], 1'b1)
            vh = (30000 * 2000 - h * 78125 + 1999) / 2000;
            shot(vh);
            `CHK(fault_active[1], 1'b1)
            shot(vh - 1);
            `CHK(fault_active[1], 1'b0)
        end
        for (int k = 0; k < 6; k++) begin
            ch = k % 3;
            thr = (k < 3) ? thrs[k] : $urandom_range(60000, 1);
            dl = $urandom_range(3, 1);
            apb(1, oci[ch] * 4, thr);
            apb(1, oci[ch] * 4 + 8, dl);
            sp = setpt(thr, ch == 2);
            setc(sp / 2000, 1'b1);
            tick(dl * MS + 12);
            `CHK(fault_active[2 + ch], 1'b0)
            setc(sp / 2000 + 1, 1'b0);
            tick(dl * MS);
            `CHK(fault_active[2 + ch], 1'b0)
            tick(6);
            `CHK(fault_active[2 + ch], 1'b1)
            if (k == 1) `CHK(fault_active[2], 1'b0)
            setc(0, 1'b0);
            tick(4);
            `CHK(fault_active[2 + ch], 1'b0)
        end
        apb(0, 16'h7fc0 * 4, 0);
        `CHK(rd, 32'h1f)
        apb(1, 16'h7fc2 * 4, 32'h1);
        `CHK(fault_irq, 1'b1)
        apb(1, 16'h7fc2 * 4, 32'h0);
        `CHK(fault_irq, 1'b0)
        apb(1, 16'h7fc1 * 4, 32'h3);
        apb(1, 16'h7fc2 * 4, 32'h1f);
        `CHK(fault_irq, 1'b1)
        apb(0, 16'h7fc0 * 4, 0);
        `CHK(rd, 32'h1c)
        apb(1, 16'h7fc1 * 4, 32'h1f);
        `CHK(fault_irq, 1'b0)
        apb(0, 16'h7fc1 * 4, 0);
        `CHK(rd, 32'h0)
        finish_test();
    end
endmodule
